// [common/tbr_defines.vh]
/*
  Constants for the trace buffer readout and tagging block: register
  offsets, field positions, modes, sequencer states, buffer geometry.
  Assumes inclusion by bare name from the design file.
*/
`ifndef TBR_DEFINES_VH
`define TBR_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TBR_OFF_CTRL 8'h00
`define TBR_OFF_CMP0 8'h04
`define TBR_OFF_CMP1 8'h08
`define TBR_OFF_CNT 8'h0c
`define TBR_OFF_PORT 8'h10
`define TBR_OFF_PORTH 8'h14

// ----------------------------------------
// control fields and reset value
// ----------------------------------------
`define TBR_C_ARM 0
`define TBR_C_TSEL 1
`define TBR_C_MODE_LO 2
`define TBR_C_ALIGN_END 4
`define TBR_C_TAG_LO 5
`define TBR_C_EN_LO 7
`define TBR_CTRL_RST 9'h000
`define TBR_CMP_RW_CHK 19
`define TBR_CMP_RW_VAL 18

// ----------------------------------------
// trace modes, sequencer states, responses
// ----------------------------------------
`define TBR_MODE_NORMAL 2'h0
`define TBR_MODE_LOOP 2'h1
`define TBR_MODE_COMP 2'h3
`define TBR_SEQ_IDLE 2'h0
`define TBR_SEQ_ARMED 2'h1
`define TBR_SEQ_FINAL 2'h2
`define TBR_RESP_OK 2'h0
`define TBR_RESP_ERR 2'h2

// ----------------------------------------
// buffer geometry and row fill codes
// ----------------------------------------
`define TBR_ROWS 64
`define TBR_PTR_W 6
`define TBR_LAST_ROW 6'h3f
`define TBR_CNT_FULL 7'h40
`define TBR_FILL_BASE 2'h0
`define TBR_FILL_ONE 2'h1
`define TBR_FILL_TWO 2'h2
`define TBR_FILL_THREE 2'h3

`endif

// [rtl/tbr_top.v]
/*
  Trace capture store with locked word readout over AXI4-Lite, compressed
  program-counter rows and opcode tagging feeding a small sequencer.
  Assumes one 10 MHz clock, trace/queue inputs synchronous to it, and
  that the buffer array sits outside any reset so rows survive it.
*/
`timescale 1ns/10ps
`default_nettype none
// Function
// - bit 3 marks source or destination
// - vector bit set forces destination bit
// - bits 1,0 hold pc bits 17,16
// - fill code gives base or 1-3 increments
// - new base row when pc[17:6] changes
// - increments offset from 64-address block start
// - first row, also after wrap, is base
// - readable only disarmed, selected, unsecured
// - arm locks; aligned word write unlocks
// - byte or misaligned reads give zero
// - oldest first; count never decrements on read
// - pointer at row 0 or oldest
// - high-half write rewinds pointer to oldest
// - row read as low word, then nibble
// - armed read gives junk, no advance
// - contents and count survive system reset
// - trace select clear reads all zeroes
// - tag select: immediate or tag opcode
// - begin alignment tag hit starts trace
// - end alignment tag hit breaks immediately
// - tagging ignores rw; word-accurate compare
// - background debug mode clears tagging
// - compressed row is 2+18 bits
`include "tbr_defines.vh"

module tbr_top (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // trace source from the cpu
  input wire trc_valid,
  input wire [17:0] trc_pc,
  input wire trc_dest,
  input wire trc_vector,
  // bus address for comparators and queue head
  input wire bus_valid,
  input wire [17:0] bus_addr,
  input wire bus_rw,
  input wire head_valid,
  input wire [17:0] head_pc,
  // system state
  input wire secured,
  input wire background_debug_mode,
  // breakpoint request
  output reg brk_req
);

// ----------------------------------------
// reset release
// ----------------------------------------
reg rst_meta_n;
reg rst_s_n;
always @(posedge clock or negedge rst_n)
begin
  if (!rst_n)
  begin
    rst_meta_n <= 1'b0;
    rst_s_n <= 1'b0;
  end
  else
  begin
    rst_meta_n <= 1'b1;
    rst_s_n <= rst_meta_n;
  end
end

// word write with full strobes and bits 1,0 clear
function aligned_word;
  input [7:0] addr;
  input [3:0] strb;
  begin
    aligned_word = (addr[1:0] == 2'h0) && (strb == 4'hf);
  end
endfunction

// tag compares drop address bit 0
function word_eq;
  input [17:0] a;
  input [17:0] b;
  begin
    word_eq = (a[17:1] == b[17:1]);
  end
endfunction

// ----------------------------------------
// state
// ----------------------------------------
reg [8:0] ctrl;
reg [19:0] cmp [0:1];
reg [1:0] seq;
reg locked;
reg [5:0] rptr;
reg half;
reg [1:0] tag_pend;
reg sess_start;
reg [7:0] aw_addr;
reg aw_held;
reg [31:0] w_data;
reg [3:0] w_strb;
reg w_held;

reg [19:0] mem [0:`TBR_ROWS-1];
reg [5:0] wptr;
reg [6:0] cnt;
reg ovf;
reg [11:0] base_hi;
reg [19:0] cur;
reg [17:0] last_src;
reg fresh;

wire armed = ctrl[`TBR_C_ARM];
wire tsel = ctrl[`TBR_C_TSEL];
wire [1:0] mode = ctrl[`TBR_C_MODE_LO+1:`TBR_C_MODE_LO];
wire align_end = ctrl[`TBR_C_ALIGN_END];
wire [5:0] oldest = ovf ? wptr : 6'h00;

// ----------------------------------------
// comparators and tags
// ----------------------------------------
wire [1:0] hit_now;
wire [1:0] tag_set;
wire [1:0] tag_hit;
genvar gi;
generate
  for (gi = 0; gi < 2; gi = gi + 1)
  begin : g_cmp
    wire en = ctrl[`TBR_C_EN_LO+gi] & armed & ~background_debug_mode;
    wire tag = ctrl[`TBR_C_TAG_LO+gi];
    wire rw_ok = ~cmp[gi][`TBR_CMP_RW_CHK] |
      (bus_rw == cmp[gi][`TBR_CMP_RW_VAL]);
    assign hit_now[gi] = en & ~tag & bus_valid & rw_ok &
      (bus_addr == cmp[gi][17:0]);
    assign tag_set[gi] = en & tag & bus_valid &
      word_eq(bus_addr, cmp[gi][17:0]);
    assign tag_hit[gi] = en & tag_pend[gi] & head_valid &
      word_eq(head_pc, cmp[gi][17:0]);
  end
endgenerate

wire trig = (|hit_now) | (|tag_hit);
wire tracing = armed & (align_end ? (seq == `TBR_SEQ_ARMED) :
  (seq == `TBR_SEQ_FINAL));
wire cap = tracing & trc_valid;

// ----------------------------------------
// row formation
// ----------------------------------------
reg do_new;
reg do_upd;
reg [19:0] row;
wire [5:0] off = trc_pc[5:0];
wire [5:0] prev = wptr - 6'h01;
always @*
begin
  do_new = 1'b0;
  do_upd = 1'b0;
  row = {2'h0, trc_pc};
  if (cap)
  begin
    if (mode == `TBR_MODE_COMP)
    begin
      if (fresh || trc_pc[17:6] != base_hi)
      begin
        do_new = 1'b1;
        row = {`TBR_FILL_BASE, trc_pc};
      end
      else if (cur[19:18] == `TBR_FILL_BASE ||
        cur[19:18] == `TBR_FILL_THREE)
      begin
        do_new = 1'b1;
        if (wptr == 6'h00)
          row = {`TBR_FILL_BASE, trc_pc};
        else
          row = {`TBR_FILL_ONE, 12'h000, off};
      end
      else if (cur[19:18] == `TBR_FILL_ONE)
      begin
        do_upd = 1'b1;
        row = {`TBR_FILL_TWO, 6'h00, off, cur[5:0]};
      end
      else
      begin
        do_upd = 1'b1;
        row = {`TBR_FILL_THREE, off, cur[11:0]};
      end
    end
    else
    begin
      // loop mode drops repeats of the last source address only
      do_new = ~(mode == `TBR_MODE_LOOP && ~trc_dest && ~trc_vector &&
        trc_pc == last_src);
      row = {trc_dest | trc_vector, trc_vector, trc_pc};
    end
  end
end

wire full_evt = do_new & (wptr == `TBR_LAST_ROW);

// ----------------------------------------
// buffer store, kept out of reset
// ----------------------------------------
always @(posedge clock)
begin
  if (sess_start)
  begin
    wptr <= 6'h00;
    cnt <= 7'h00;
    ovf <= 1'b0;
    fresh <= 1'b1;
    cur <= 20'h00000;
  end
  else if (do_new)
  begin
    mem[wptr] <= row;
    cur <= row;
    wptr <= wptr + 6'h01;
    fresh <= 1'b0;
    if (row[19:18] == `TBR_FILL_BASE)
      base_hi <= trc_pc[17:6];
    if (~trc_dest)
      last_src <= trc_pc;
    if (cnt != `TBR_CNT_FULL)
      cnt <= cnt + 7'h01;
    if (wptr == `TBR_LAST_ROW)
      ovf <= 1'b1;
  end
  else if (do_upd)
  begin
    mem[prev] <= row;
    cur <= row;
  end
end

// ----------------------------------------
// readout data
// ----------------------------------------
wire [19:0] rd_row = mem[rptr];
wire [31:0] port_word = half ? {28'h0000000, rd_row[19:16]} :
  {16'h0000, rd_row[15:0]};

// ----------------------------------------
// bus write and control
// ----------------------------------------
wire aw_take = s_axi_awvalid & s_axi_awready;
wire w_take = s_axi_wvalid & s_axi_wready;
wire wr_go = aw_held & w_held & ~s_axi_bvalid;
wire wr_al = aligned_word(aw_addr, w_strb);
wire ar_take = s_axi_arvalid & s_axi_arready;
wire rd_al = (s_axi_araddr[1:0] == 2'h0);
wire rd_port = ar_take & (s_axi_araddr == `TBR_OFF_PORT);
wire rd_adv = rd_port & rd_al & tsel & ~armed & ~locked & ~secured;
reg next_aw_held;
reg next_w_held;
reg next_bvalid;
always @*
begin
  next_aw_held = (aw_held | aw_take) & ~wr_go;
  next_w_held = (w_held | w_take) & ~wr_go;
  next_bvalid = wr_go | (s_axi_bvalid & ~s_axi_bready);
end

always @(posedge clock or negedge rst_s_n)
begin
  if (!rst_s_n)
  begin
    s_axi_awready <= 1'b0;
    s_axi_wready <= 1'b0;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `TBR_RESP_OK;
    aw_held <= 1'b0;
    w_held <= 1'b0;
    aw_addr <= 8'h00;
    w_data <= 32'h00000000;
    w_strb <= 4'h0;
    ctrl <= `TBR_CTRL_RST;
    cmp[0] <= 20'h00000;
    cmp[1] <= 20'h00000;
    seq <= `TBR_SEQ_IDLE;
    locked <= 1'b1;
    rptr <= 6'h00;
    half <= 1'b0;
    tag_pend <= 2'h0;
    sess_start <= 1'b0;
    brk_req <= 1'b0;
  end
  else
  begin
    aw_held <= next_aw_held;
    w_held <= next_w_held;
    s_axi_bvalid <= next_bvalid;
    s_axi_awready <= ~next_aw_held & ~next_bvalid;
    s_axi_wready <= ~next_w_held & ~next_bvalid;
    if (aw_take)
      aw_addr <= s_axi_awaddr;
    if (w_take)
    begin
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    sess_start <= 1'b0;
    brk_req <= 1'b0;
    // sequencer; bus writes below override on the same edge
    if (background_debug_mode)
      tag_pend <= 2'h0;
    else
      // a fresh tag in the hit cycle must survive, so set wins
      tag_pend <= (tag_pend & ~tag_hit) | tag_set;
    if (seq == `TBR_SEQ_ARMED && trig)
    begin
      if (align_end)
      begin
        // end alignment: stop now and break before the opcode runs
        ctrl[`TBR_C_ARM] <= 1'b0;
        seq <= `TBR_SEQ_IDLE;
        brk_req <= 1'b1;
      end
      else
        seq <= `TBR_SEQ_FINAL;
    end
    if (seq == `TBR_SEQ_FINAL && full_evt)
    begin
      ctrl[`TBR_C_ARM] <= 1'b0;
      seq <= `TBR_SEQ_IDLE;
      brk_req <= 1'b1;
    end
    if (rd_adv)
    begin
      half <= ~half;
      if (half)
        rptr <= rptr + 6'h01;
    end
    if (wr_go)
    begin
      s_axi_bresp <= `TBR_RESP_OK;
      case (aw_addr)
        `TBR_OFF_CTRL:
        begin
          ctrl <= w_data[8:0];
          if (w_data[`TBR_C_ARM])
          begin
            locked <= 1'b1;
            tag_pend <= 2'h0;
            if (~armed)
            begin
              sess_start <= 1'b1;
              seq <= `TBR_SEQ_ARMED;
            end
          end
          else
            seq <= `TBR_SEQ_IDLE;
        end
        `TBR_OFF_CMP0: cmp[0] <= w_data[19:0];
        `TBR_OFF_CMP1: cmp[1] <= w_data[19:0];
        `TBR_OFF_CNT: s_axi_bresp <= `TBR_RESP_OK;
        `TBR_OFF_PORT:
        begin
          if (wr_al && ~armed)
          begin
            locked <= 1'b0;
            rptr <= oldest;
            half <= 1'b0;
          end
        end
        `TBR_OFF_PORTH:
        begin
          if (wr_al)
          begin
            rptr <= oldest;
            half <= 1'b0;
          end
        end
        default: s_axi_bresp <= `TBR_RESP_ERR;
      endcase
    end
  end
end

// ----------------------------------------
// bus read
// ----------------------------------------
always @(posedge clock or negedge rst_s_n)
begin
  if (!rst_s_n)
  begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid <= 1'b0;
    s_axi_rdata <= 32'h00000000;
    s_axi_rresp <= `TBR_RESP_OK;
  end
  else
  begin
    if (ar_take)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TBR_RESP_OK;
      s_axi_rdata <= 32'h00000000;
      case (s_axi_araddr)
        `TBR_OFF_CTRL: s_axi_rdata <= {23'h000000, ctrl};
        `TBR_OFF_CMP0: s_axi_rdata <= {12'h000, cmp[0]};
        `TBR_OFF_CMP1: s_axi_rdata <= {12'h000, cmp[1]};
        `TBR_OFF_CNT:
          s_axi_rdata <= {20'h00000, seq, locked, ovf, 1'b0, cnt};
        `TBR_OFF_PORT:
        begin
          // armed reads with trace select set and unsecured hand back whatever row the pointer sits on
          if (tsel && ~secured && (armed || ~locked))
            s_axi_rdata <= port_word;
        end
        `TBR_OFF_PORTH: s_axi_rdata <= 32'h00000000;
        default:
        begin
          if (rd_al)
            s_axi_rresp <= `TBR_RESP_ERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (~s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end
end

endmodule
`default_nettype wire

// [bench/tbr_checker.sv]
/*
  Port-level checks for the trace buffer readout block.
  Assumes binding onto tbr_top, one clock, rst_n low resets.
*/
`timescale 1ns/10ps
`default_nettype none
module tbr_checker (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // axi read and write handshakes
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  // system state and breakpoint
  input wire logic secured,
  input wire logic brk_req
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (wr_take |=> ##[0:1] s_axi_bvalid)
    else $error("write answer missing");
  a_ready_drop: assert property (
    wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write readies stayed high");
  a_misalign_zero: assert property (
    rd_take ##0 s_axi_araddr[1:0] != 2'h0 |=> s_axi_rdata == 32'h0)
    else $error("misaligned read not zero");
  a_secured_zero: assert property (
    rd_take ##0 (secured && s_axi_araddr == 8'h10)
    |=> s_axi_rdata == 32'h0)
    else $error("secured read not zero");
  a_port_upper: assert property (
    rd_take ##0 s_axi_araddr == 8'h10 |=> s_axi_rdata[31:16] == 16'h0)
    else $error("port upper half not zero");
  a_high_zero: assert property (
    rd_take ##0 s_axi_araddr == 8'h14 |=> s_axi_rdata == 32'h0)
    else $error("high port read not zero");
  a_unmapped_rd: assert property (
    rd_take ##0 (s_axi_araddr >= 8'h18 && s_axi_araddr[1:0] == 2'h0)
    |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_brk_pulse: assert property ($rose(brk_req) |=> !brk_req)
    else $error("breakpoint longer than one cycle");
endmodule
bind tbr_top tbr_checker chk_u (.clock, .rst_n, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .secured, .brk_req);
`default_nettype wire

// [bench/tbr_cpu_model.sv]
/*
  Processor side: trace entries, bus accesses, queue head opcodes.
  Assumes the bench calls its tasks just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tbr_cpu_model (
  // clock
  input wire logic clock,
  // trace source
  output var logic trc_valid = 1'h0,
  output var logic [17:0] trc_pc = 18'h0,
  output var logic trc_dest = 1'h0,
  output var logic trc_vector = 1'h0,
  // bus and queue head
  output var logic bus_valid = 1'h0,
  output var logic [17:0] bus_addr = 18'h0,
  output var logic bus_rw = 1'h1,
  output var logic head_valid = 1'h0,
  output var logic [17:0] head_pc = 18'h0
);
  // idle fields flip so a late sample cannot match by luck
  task automatic send(input logic [17:0] pc, input logic d, input logic v);
    @(posedge clock);
    trc_valid <= 1'h1;
    trc_pc <= pc;
    trc_dest <= d;
    trc_vector <= v;
    @(posedge clock);
    trc_valid <= 1'h0;
    trc_pc <= ~pc;
    trc_dest <= ~d;
    trc_vector <= ~v;
  endtask
  task automatic bus(input logic [17:0] a);
    @(posedge clock);
    bus_valid <= 1'h1;
    bus_addr <= a;
    bus_rw <= 1'h0;
    @(posedge clock);
    bus_valid <= 1'h0;
    bus_addr <= ~a;
    bus_rw <= 1'h1;
  endtask
  task automatic head(input logic [17:0] a);
    @(posedge clock);
    head_valid <= 1'h1;
    head_pc <= a;
    @(posedge clock);
    head_valid <= 1'h0;
    head_pc <= ~a;
  endtask
endmodule
`default_nettype wire

// [bench/test_trace_buffer_readout_and_tagging.sv]
/*
  Bench: register and trace port traffic over axi4-lite with a cpu model.
  Assumes tbr_top with its defines header on the include path.
*/
`timescale 1ns/10ps
`default_nettype none
`include "tbr_defines.vh"
module test_trace_buffer_readout_and_tagging;
  localparam logic [31:0] FM = 32'hffff_ffff;
  localparam logic [1:0] OK = `TBR_RESP_OK;
  logic clock, rst_n, secured, background_debug_mode, brk_req;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, trc_valid, trc_dest, trc_vector;
  logic bus_valid, bus_rw, head_valid;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [17:0] trc_pc, bus_addr, head_pc;
  int mismatches = 0;
  int checks_done = 0;
  int brk_cnt = 0;
  logic [17:0] pcs [0:2] = '{18'h12345, 18'h2abcd, 18'h30f0f};
  logic dst [0:2] = '{1'h0, 1'h0, 1'h1};
  logic vec [0:2] = '{1'h0, 1'h1, 1'h0};
  logic [17:0] cps [0:3] = '{18'h40, 18'h41, 18'h42, 18'h80};
  // base, two increments at offsets 1 and 2, new base
  logic [15:0] cws [0:5] = '{16'h40, 16'h0, 16'h81, 16'h8, 16'h80, 16'h0};
  tbr_top dut_u (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trc_valid, .trc_pc,
    .trc_dest, .trc_vector, .bus_valid, .bus_addr, .bus_rw, .head_valid,
    .head_pc, .secured, .background_debug_mode, .brk_req);
  tbr_cpu_model cpu_u (.clock, .trc_valid, .trc_pc, .trc_dest,
    .trc_vector, .bus_valid, .bus_addr, .bus_rw, .head_valid, .head_pc);
  initial
  begin
    clock = 1'h0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
    if (brk_req === 1'h1)
      brk_cnt <= brk_cnt + 1;
  task automatic wrap_up;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      mismatches++;
      $display("CHECK FAILED handshake expected answer seen none");
      wrap_up();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (s_axi_bvalid !== 1'h1 && n < 40);
    s_axi_bready <= 1'h0;
    tmo(n);
    chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [31:0] m, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clock);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (s_axi_rvalid !== 1'h1 && n < 40);
    s_axi_rready <= 1'h0;
    tmo(n);
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  task automatic rst;
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
  endtask
  initial
  begin
    int i;
    int j;
    logic [31:0] e;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, secured, background_debug_mode} = 4'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    rst_n = 1'h0;
    rst();
    rd(`TBR_OFF_CTRL, 32'h0, FM, OK);
    rd(`TBR_OFF_CNT, 32'h200, 32'h200, OK);
    wr(`TBR_OFF_CMP0, 32'hc1230, OK);
    wr(`TBR_OFF_CTRL, 32'hb3, OK);
    for (i = 0; i < 3; i++)
      cpu_u.send(pcs[i], dst[i], vec[i]);
    cpu_u.bus(18'h1230);
    cpu_u.head(18'h1230);
    rd(`TBR_OFF_CNT, 32'h203, 32'h37f, OK);
    chk("brk", 32'h1, brk_cnt);
    wr(`TBR_OFF_PORT, 32'h0, OK);
    rd(8'h11, 32'h0, FM, OK);
    for (i = 0; i < 3; i++)
    begin
      rd(`TBR_OFF_PORT, {16'h0, pcs[i][15:0]}, FM, OK);
      rd(`TBR_OFF_PORT, {28'h0, dst[i] | vec[i], vec[i],
        pcs[i][17:16]}, FM, OK);
    end
    rd(`TBR_OFF_CNT, 32'h3, 32'h7f, OK);
    rd(`TBR_OFF_PORTH, 32'h0, FM, OK);
    wr(`TBR_OFF_PORTH, 32'h0, OK);
    rd(`TBR_OFF_PORT, 32'h2345, FM, OK);
    secured <= 1'h1;
    rd(`TBR_OFF_PORT, 32'h0, FM, OK);
    secured <= 1'h0;
    rd(8'h20, 32'h0, 32'h0, `TBR_RESP_ERR);
    wr(8'h30, 32'h0, `TBR_RESP_ERR);
    rst();
    rd(`TBR_OFF_CNT, 32'h203, 32'h27f, OK);
    wr(`TBR_OFF_PORT, 32'h0, OK);
    rd(`TBR_OFF_PORT, 32'h0, FM, OK);
    wr(`TBR_OFF_CTRL, 32'h2, OK);
    rd(`TBR_OFF_PORT, 32'h2345, FM, OK);
    wr(`TBR_OFF_CMP0, 32'hc1230, OK);
    wr(`TBR_OFF_CMP1, 32'h2000, OK);
    wr(`TBR_OFF_CTRL, 32'h1bf, OK);
    for (i = 0; i < 4; i++)
      cpu_u.send(cps[i], 1'h0, 1'h0);
    cpu_u.bus(18'h1230);
    background_debug_mode <= 1'h1;
    @(posedge clock);
    background_debug_mode <= 1'h0;
    cpu_u.head(18'h1230);
    rd(`TBR_OFF_CNT, 32'h3, 32'h7f, OK);
    chk("brk", 32'h1, brk_cnt);
    cpu_u.bus(18'h2000);
    wr(`TBR_OFF_PORT, 32'h0, OK);
    for (i = 0; i < 6; i++)
      rd(`TBR_OFF_PORT, {16'h0, cws[i]}, FM, OK);
    chk("brk", 32'h2, brk_cnt);
    // begin alignment with loop filter, runs until the buffer is full
    wr(`TBR_OFF_CTRL, 32'ha7, OK);
    cpu_u.send(18'h300, 1'h0, 1'h0);
    cpu_u.bus(18'h1231);
    cpu_u.head(18'h1230);
    chk("brk", 32'h2, brk_cnt);
    rd(`TBR_OFF_PORT, 32'h0, 32'h0, OK);
    cpu_u.send(18'h100, 1'h0, 1'h0);
    cpu_u.send(18'h100, 1'h0, 1'h0);
    cpu_u.send(18'h100, 1'h1, 1'h0);
    for (i = 2; i < 64; i++)
      cpu_u.send(18'h200 + 18'(i), 1'h0, 1'h0);
    rd(`TBR_OFF_CNT, 32'h340, 32'hfff, OK);
    chk("brk", 32'h3, brk_cnt);
    wr(`TBR_OFF_PORT, 32'h0, OK);
    rd(`TBR_OFF_PORT, 32'h100, FM, OK);
    rd(`TBR_OFF_PORT, 32'h0, FM, OK);
    rd(`TBR_OFF_PORT, 32'h100, FM, OK);
    rd(`TBR_OFF_PORT, 32'h8, FM, OK);
    rd(`TBR_OFF_PORT, 32'h202, FM, OK);
    // end alignment, compressed rows, wrap past the last row
    wr(`TBR_OFF_CTRL, 32'h11f, OK);
    for (i = 0; i < 64; i++)
      cpu_u.send(18'((i + 1) * 64), 1'h0, 1'h0);
    cpu_u.send(18'h1003, 1'h0, 1'h0);
    cpu_u.send(18'h1005, 1'h0, 1'h0);
    cpu_u.bus(18'h2000);
    rd(`TBR_OFF_CNT, 32'h340, 32'hfff, OK);
    chk("brk", 32'h4, brk_cnt);
    wr(`TBR_OFF_PORT, 32'h0, OK);
    for (i = 0; i < 64; i++)
    begin
      j = (i + 2) % 64;
      e = (j == 0) ? 32'h1003 : ((j == 1) ? 32'h40005 : (j + 1) * 64);
      rd(`TBR_OFF_PORT, e & 32'hffff, FM, OK);
      rd(`TBR_OFF_PORT, e >> 16, FM, OK);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
